//--- design/slethm_lane_cnt.sv
// Purpose: Error counters for one lane, three error kinds
// Assumes: Error strobes are same-clock single-cycle pulses
// Notes:   Counts saturate; reached flags compare against the threshold
`timescale 1ns/100ps
`default_nettype none
module slethm_lane_cnt
  import slethm_pkg::*;
(
  input  wire logic        clk_i,    // System clock
  input  wire logic        rst_i,    // Sync reset, active high
  input  wire logic        clr_i,    // Link reset or resync
  input  wire slethm_err_t err_i,    // Error strobes
  input  wire logic [7:0]  thresh_i, // Threshold value
  output logic [2:0]       hit_o     // Count reached threshold, registered
);

  logic [7:0] cnt_q [3];
  logic [7:0] cnt_d [3];
  logic [2:0] hit_d;
  logic [2:0] hit_q;
  logic [2:0] ev;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : 8'(v + 8'h01);
  endfunction

  assign ev = {err_i.ctrl, err_i.code, err_i.disp};

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (clr_i) begin
        cnt_d[k] = 8'h00; // R13
      end else if (ev[k]) begin
        cnt_d[k] = sat_inc(cnt_q[k]); // R9
      end else begin
        cnt_d[k] = cnt_q[k];
      end
      hit_d[k] = !clr_i && (thresh_i != 8'h00) && (cnt_d[k] >= thresh_i); // R9
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 3; k++) begin
        cnt_q[k] <= 8'h00;
      end
      hit_q <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        cnt_q[k] <= cnt_d[k];
      end
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule
`default_nettype wire

//--- design/slethm_top.sv
// Purpose: Per-lane error threshold and configuration mismatch monitor
// Assumes: Wishbone classic slave; error strobes and config words on clk_i
// Notes:   Sync request and irq outputs are active low, registered
// How it works
// R1: With the disparity sync enable set, any lane's disparity count at threshold asserts sync.
// R2: With the invalid-code sync enable set, a lane's invalid-code count at threshold asserts sync.
// R3: With the control-char sync enable set, a lane's control-char count at threshold asserts sync.
// R4: With mismatch reporting on, the mismatch flag latches on a mismatch rising edge and pulls irq low.
// R5: Writing one to the mismatch flag clears it and releases its interrupt.
// R6: With mismatch reporting off, the mismatch flag neither latches nor affects irq.
// R7: Mismatch reporting enable is bit 3 of the control register and resets to one.
// R8: A mismatch is any difference between lane-0 received config and local transmit config.
// R9: Each error kind is counted and compared with an 8-bit programmable threshold.
// R10: A threshold hit raises irq, sync, or both, as mask and sync enables select.
// R11: Counting and comparison run independently on every lane.
// R12: A set error mask bit pulls the active-low irq low when that count hits threshold on any lane.
// R13: Lane error counters clear on link reset or resync.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module slethm_top
  import slethm_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic                   clk_i,      // System clock, 100 MHz
  input  wire logic                   rst_i,      // Sync reset, active high
  input  wire logic                   wb_cyc_i,   // Wishbone cycle
  input  wire logic                   wb_stb_i,   // Wishbone strobe
  input  wire logic                   wb_we_i,    // Wishbone write
  input  wire logic [3:0]             wb_sel_i,   // Wishbone byte select
  input  wire logic [13:0]            wb_adr_i,   // Wishbone byte address
  input  wire logic [31:0]            wb_dat_i,   // Wishbone write data
  output logic [31:0]                 wb_dat_o,   // Wishbone read data
  output logic                        wb_ack_o,   // Wishbone ack
  input  wire slethm_err_t [LANES-1:0] lane_err_i, // Per-lane error strobes
  input  wire logic                   link_clr_i, // Link reset or resync pulse
  input  wire logic [CFG_WORDS*8-1:0] rx_cfg_i,   // Lane-0 received config
  input  wire logic [CFG_WORDS*8-1:0] tx_cfg_i,   // Local transmit config
  output logic                        sync_n_o,   // Link sync output, low = request
  output logic                        irq_n_o     // Interrupt, active low
);

  // Registers
  logic [7:0]       ctrl_q,  ctrl_d;
  logic [7:0]       thr_q,   thr_d;
  logic [3:0]       stat_q,  stat_d;
  logic [3:0]       mask_q,  mask_d;
  logic             sclr_q,  sclr_d;
  logic             mm_q,    mm_d;
  logic             ack_q,   ack_d;
  logic [31:0]      rdat_q,  rdat_d;
  logic             sync_n_q, sync_n_d;
  logic             irq_n_q,  irq_n_d;

  logic [LANES-1:0] hit_disp, hit_code, hit_ctrl;
  logic [2:0]       hit_any;
  logic             mm_now, mm_rise, req, wr, rd;
  logic [11:0]      idx;

  function automatic logic sel_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Lane counters
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [2:0] h;
    slethm_lane_cnt u_cnt (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (link_clr_i | sclr_q), // R13
      .err_i    (lane_err_i[g]),
      .thresh_i (thr_q),
      .hit_o    (h)
    ); // R11
    assign hit_disp[g] = h[0];
    assign hit_code[g] = h[1];
    assign hit_ctrl[g] = h[2];
  end

  assign hit_any = {|hit_ctrl, |hit_code, |hit_disp};
  assign mm_now  = (rx_cfg_i != tx_cfg_i); // R8
  assign mm_rise = mm_now && !mm_q;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign rd  = req && !wb_we_i;
  assign idx = wb_adr_i[13:2];

  // Bus answer: ack one cycle after the taking edge, read data with it
  always_comb begin
    ack_d  = req;
    rdat_d = 32'h0000_0000;
    if (rd) begin
      unique case (idx)
        SYNC_CTRL_IDX: rdat_d = {24'h000000, ctrl_q};
        THRESH_IDX:    rdat_d = {24'h000000, thr_q};
        ERR_STAT_IDX:  rdat_d = {28'h0000000, stat_q};
        ERR_MASK_IDX:  rdat_d = {28'h0000000, mask_q};
        LANE_STAT_IDX: rdat_d = 32'({hit_ctrl, hit_code, hit_disp}); // R11
        default:       rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Control, threshold, mask and software counter clear
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d  = thr_q;
    mask_d = mask_q;
    sclr_d = 1'b0;
    mm_d   = mm_now;
    if (wr && sel_hit(idx, SYNC_CTRL_IDX)) begin
      ctrl_d[7:5] = wb_dat_i[7:5];
      ctrl_d[MM_ENABLE_BIT] = wb_dat_i[MM_ENABLE_BIT]; // R7
      if (wb_dat_i[MISMATCH_BIT]) begin
        ctrl_d[MISMATCH_BIT] = 1'b0; // R5
      end
    end
    // A fresh mismatch edge beats the write-one clear
    if (!ctrl_d[MM_ENABLE_BIT]) begin
      ctrl_d[MISMATCH_BIT] = 1'b0; // R6
    end else if (mm_rise) begin
      ctrl_d[MISMATCH_BIT] = 1'b1; // R4
    end
    ctrl_d[2:0] = 3'h0;
    if (wr && sel_hit(idx, THRESH_IDX)) begin
      thr_d = wb_dat_i[7:0]; // R9
    end
    if (wr && sel_hit(idx, ERR_MASK_IDX)) begin
      mask_d = wb_dat_i[3:0];
    end
    if (wr && sel_hit(idx, LINK_CLR_IDX)) begin
      sclr_d = wb_dat_i[0]; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= SYNC_CTRL_RST; // R7
      thr_q  <= THRESH_RST;
      mask_q <= ERR_MASK_RST;
      sclr_q <= 1'b0;
      mm_q   <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q  <= thr_d;
      mask_q <= mask_d;
      sclr_q <= sclr_d;
      mm_q   <= mm_d;
    end
  end

  // Sticky status, cleared by a read of its register
  always_comb begin
    stat_d = stat_q;
    if (rd && sel_hit(idx, ERR_STAT_IDX)) begin
      stat_d = 4'h0;
    end
    // New events win over the read clear
    stat_d[EV_DISP] = stat_d[EV_DISP] | hit_any[0]; // R10
    stat_d[EV_CODE] = stat_d[EV_CODE] | hit_any[1]; // R10
    stat_d[EV_CTRL] = stat_d[EV_CTRL] | hit_any[2]; // R10
    stat_d[EV_MM]   = stat_d[EV_MM] | (mm_rise & ctrl_q[MM_ENABLE_BIT]); // R4
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Sync request and interrupt pins, both active low
  always_comb begin
    sync_n_d = !((ctrl_q[DISP_SYNC_BIT] && hit_any[0])    // R1 R10
              || (ctrl_q[CODE_SYNC_BIT] && hit_any[1])    // R2
              || (ctrl_q[CTRL_SYNC_BIT] && hit_any[2]));  // R3
    irq_n_d  = !((|(stat_q[2:0] & mask_q[2:0]))           // R12 R10
              || (ctrl_q[MISMATCH_BIT] && ctrl_q[MM_ENABLE_BIT]) // R4 R6
              || (stat_q[EV_MM] && mask_q[EV_MM]));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_n_q <= 1'b1;
      irq_n_q  <= 1'b1;
    end else begin
      sync_n_q <= sync_n_d;
      irq_n_q  <= irq_n_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign sync_n_o = sync_n_q;
  assign irq_n_o  = irq_n_q;

  // Assertions
  disp_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[DISP_SYNC_BIT] && hit_any[0]) |=> !sync_n_o) // R1
    else $error("disparity hit did not request sync");
  code_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[CODE_SYNC_BIT] && hit_any[1]) |=> !sync_n_o) // R2
    else $error("invalid code hit did not request sync");
  ctrl_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[CTRL_SYNC_BIT] && hit_any[2]) |=> !sync_n_o) // R3
    else $error("control char hit did not request sync");
  mm_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mm_rise && ctrl_q[MM_ENABLE_BIT] && !wr) |=> ##1 (ctrl_q[MISMATCH_BIT] && !irq_n_o)) // R4
    else $error("mismatch flag or irq missing");
  mm_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && sel_hit(idx, SYNC_CTRL_IDX) && wb_dat_i[MISMATCH_BIT] && !mm_rise)
    |=> !ctrl_q[MISMATCH_BIT]) // R5
    else $error("mismatch flag not cleared by write");
  mm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q[MM_ENABLE_BIT] |-> !ctrl_q[MISMATCH_BIT]) // R6
    else $error("mismatch flag set while disabled");
  sync_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[7:5] == 3'h0) |=> sync_n_o) // R10
    else $error("sync asserted with all enables off");
  mask_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_q[EV_DISP] && hit_any[0]) |=> ##1 !irq_n_o) // R12
    else $error("masked disparity hit did not raise irq");
  clr_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    link_clr_i |=> (hit_any == 3'h0)) // R13
    else $error("link clear left a threshold hit");
  sw_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    sclr_q |=> (hit_any == 3'h0))
    else $error("software clear left a threshold hit");
  thr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (thr_q == 8'h00) |=> (hit_any == 3'h0))
    else $error("threshold zero produced a hit");
  code_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (mask_q[EV_CODE] && hit_any[1]) |=> ##1 !irq_n_o)
    else $error("masked invalid code hit did not raise irq");
  ctrl_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (mask_q[EV_CTRL] && hit_any[2]) |=> ##1 !irq_n_o)
    else $error("masked control char hit did not raise irq");
  mm_nolatch_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (!ctrl_q[MM_ENABLE_BIT] && mm_rise && !wr) |=> !ctrl_q[MISMATCH_BIT])
    else $error("mismatch latched while reporting off");
  mm_flag_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (ctrl_q[MISMATCH_BIT] && ctrl_q[MM_ENABLE_BIT]) |=> !irq_n_o)
    else $error("latched mismatch did not hold irq low");
  mm_stat_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (mm_rise && ctrl_q[MM_ENABLE_BIT]) |=> stat_q[EV_MM])
    else $error("mismatch status bit not set");

  // Status bits follow hits and stay until read
  disp_stat_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    hit_any[0] |=> stat_q[EV_DISP])
    else $error("disparity hit missing from status");
  code_stat_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    hit_any[1] |=> stat_q[EV_CODE])
    else $error("invalid code hit missing from status");
  ctrl_stat_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    hit_any[2] |=> stat_q[EV_CTRL])
    else $error("control char hit missing from status");
  stat_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (stat_q[EV_DISP] && !(rd && sel_hit(idx, ERR_STAT_IDX))) |=> stat_q[EV_DISP])
    else $error("disparity status lost without a read");
  sync_rel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (hit_any == 3'h0) |=> sync_n_o)
    else $error("sync requested with no hit");

  // Bus answer shape
  ack_resp_a: assert property (@(posedge clk_i) disable iff (rst_i) // Local design decision: register access over Wishbone
    req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // Local design decision: register access over Wishbone
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  rd_cov: cover property (@(posedge clk_i) rd && ack_d);
  sync_cov: cover property (@(posedge clk_i) $fell(sync_n_o));
  irq_cov: cover property (@(posedge clk_i) $fell(irq_n_o));
  mm_cov: cover property (@(posedge clk_i) mm_rise && ctrl_q[MM_ENABLE_BIT]);
  sclr_cov: cover property (@(posedge clk_i) sclr_q && (hit_any != 3'h0));

endmodule
`default_nettype wire

//--- shared/slethm_pkg.sv
// Purpose: Constants and types for the link error threshold monitor
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Printed offsets are register indices; byte address is four times the index
package slethm_pkg;

  // Register indices as printed, byte address = index * 4
  localparam logic [11:0] SYNC_CTRL_IDX   = 12'h47b;
  localparam logic [11:0] THRESH_IDX      = 12'h47c;
  localparam logic [11:0] ERR_STAT_IDX    = 12'h47e;
  localparam logic [11:0] ERR_MASK_IDX    = 12'h47f;
  localparam logic [11:0] LANE_STAT_IDX   = 12'h480;
  localparam logic [11:0] LINK_CLR_IDX    = 12'h481;

  // Control register fields
  localparam int DISP_SYNC_BIT   = 7;
  localparam int CODE_SYNC_BIT   = 6;
  localparam int CTRL_SYNC_BIT   = 5;
  localparam int MISMATCH_BIT    = 4;
  localparam int MM_ENABLE_BIT   = 3;

  localparam logic [7:0] SYNC_CTRL_RST  = 8'h08;
  localparam logic [7:0] THRESH_RST     = 8'hff;
  localparam logic [3:0] ERR_MASK_RST   = 4'h0;

  // Status / mask layout
  localparam int EV_DISP = 0;
  localparam int EV_CODE = 1;
  localparam int EV_CTRL = 2;
  localparam int EV_MM   = 3;
  localparam int NUM_EV  = 4;

  // Number of configuration words compared (0x450..0x45d against 0x400..0x40d)
  localparam int CFG_WORDS = 14;

  typedef struct packed {
    logic disp;
    logic code;
    logic ctrl;
  } slethm_err_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [13:0] adr;
    logic [31:0] dat;
  } slethm_wb_req_t;

endpackage

//--- tb/slethm_top_tb.sv
// Purpose: Self-checking bench for the error threshold monitor
// Assumes: Threshold 3, all error kinds masked into irq
// Notes:   Ordinary threshold cases run as table rows
`timescale 1ns/100ps
`default_nettype none
module slethm_top_tb;
  import slethm_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] lane;
    logic [7:0] ctrl;
    logic       sync_n;
  } slethm_row_t;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cyc = 1'b0;
  logic                   stb = 1'b0;
  logic                   we = 1'b0;
  logic                   link_clr = 1'b0;
  logic [13:0]            adr = '0;
  logic [31:0]            dat = '0;
  logic [31:0]            rd;
  logic [31:0]            wb_dat;
  logic                   wb_ack;
  logic                   sync_n;
  logic                   irq_n;
  slethm_err_t [7:0]      lane_err;
  logic [CFG_WORDS*8-1:0] tx_cfg = {CFG_WORDS{8'h5a}};
  logic [CFG_WORDS*8-1:0] rx_cfg;
  int                     errors = 0;
  int                     comparisons = 0;
  slethm_row_t            rows [4];

  always #5 clk_i = ~clk_i;

  slethm_top #(.LANES(8)) slethm_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .lane_err_i(lane_err), .link_clr_i(link_clr),
    .rx_cfg_i(rx_cfg), .tx_cfg_i(tx_cfg), .sync_n_o(sync_n), .irq_n_o(irq_n)
  );
  slethm_tx_model slethm_tx_model_i (
    .clk_i(clk_i), .tx_cfg_i(tx_cfg), .lane_err_o(lane_err), .rx_cfg_o(rx_cfg)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle, held until ack is sampled
  task automatic wb(input logic [11:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #300us;
    errors++;
    end_sim();
  end

  initial begin
    rows[0] = '{2'd0, 3'd0, 8'h88, 1'b0};
    rows[1] = '{2'd1, 3'd3, 8'h48, 1'b0};
    rows[2] = '{2'd2, 3'd7, 8'h28, 1'b0};
    rows[3] = '{2'd0, 3'd5, 8'h68, 1'b1};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(SYNC_CTRL_IDX, 1'b0, 8'h00);
    chk(rd, 32'h08);
    wb(THRESH_IDX, 1'b0, 8'h00);
    chk(rd, 32'hff);
    wb(12'h7ff, 1'b1, 8'hff);
    wb(12'h7ff, 1'b0, 8'h00);
    chk(rd, 32'h0);
    wb(THRESH_IDX, 1'b1, 8'h03);
    wb(ERR_MASK_IDX, 1'b1, 8'h07);
    foreach (rows[i]) begin
      wb(SYNC_CTRL_IDX, 1'b1, rows[i].ctrl);
      slethm_tx_model_i.burst(rows[i].lane, rows[i].kind, 2);
      repeat (4) @(posedge clk_i);
      chk(sync_n, 32'h1);
      chk(irq_n, 32'h1);
      slethm_tx_model_i.burst(rows[i].lane, rows[i].kind, 1);
      repeat (4) @(posedge clk_i);
      chk(sync_n, rows[i].sync_n);
      chk(irq_n, 32'h0);
      wb(LANE_STAT_IDX, 1'b0, 8'h00);
      chk(rd, 32'h1 << (rows[i].lane + 8 * rows[i].kind));
      @(posedge clk_i);
      link_clr <= 1'b1;
      @(posedge clk_i);
      link_clr <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(sync_n, 32'h1);
      wb(ERR_STAT_IDX, 1'b0, 8'h00);
      chk(rd, 32'h1 << rows[i].kind);
      wb(ERR_STAT_IDX, 1'b0, 8'h00);
      chk(rd, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(irq_n, 32'h1);
    end
    // Mismatch latch and write-one clear
    wb(SYNC_CTRL_IDX, 1'b1, 8'h08);
    slethm_tx_model_i.set_bad(1'b1);
    repeat (4) @(posedge clk_i);
    chk(irq_n, 32'h0);
    wb(SYNC_CTRL_IDX, 1'b0, 8'h00);
    chk(rd, 32'h18);
    wb(SYNC_CTRL_IDX, 1'b1, 8'h18);
    repeat (2) @(posedge clk_i);
    chk(irq_n, 32'h1);
    wb(SYNC_CTRL_IDX, 1'b0, 8'h00);
    chk(rd, 32'h08);
    // Reporting disabled: no latch, no irq
    slethm_tx_model_i.set_bad(1'b0);
    wb(SYNC_CTRL_IDX, 1'b1, 8'h00);
    slethm_tx_model_i.set_bad(1'b1);
    repeat (4) @(posedge clk_i);
    chk(irq_n, 32'h1);
    wb(SYNC_CTRL_IDX, 1'b0, 8'h00);
    chk(rd, 32'h00);
    // Software counter clear, then threshold zero never hits
    wb(SYNC_CTRL_IDX, 1'b1, 8'h48);
    slethm_tx_model_i.burst(1, 1, 3);
    repeat (4) @(posedge clk_i);
    chk(sync_n, 32'h0);
    wb(LINK_CLR_IDX, 1'b1, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(sync_n, 32'h1);
    wb(THRESH_IDX, 1'b1, 8'h00);
    slethm_tx_model_i.burst(1, 1, 3);
    repeat (4) @(posedge clk_i);
    chk(sync_n, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire

//--- tb/slethm_tx_model.sv
// Purpose: Transmitter stand-in: lane error strobes and lane-0 config
// Assumes: Changes only right after rising clock edges
// Notes:   Mismatch made by flipping one received config bit
`timescale 1ns/100ps
`default_nettype none
module slethm_tx_model
  import slethm_pkg::*;
(
  input  wire logic                   clk_i,      // System clock
  input  wire logic [CFG_WORDS*8-1:0] tx_cfg_i,   // Local transmit config
  output var slethm_err_t [7:0]       lane_err_o, // Error strobes
  output logic [CFG_WORDS*8-1:0]      rx_cfg_o    // Lane-0 received config
);
  logic bad;
  initial begin
    lane_err_o = '0;
    bad = 1'b0;
  end
  assign rx_cfg_o = tx_cfg_i ^ {{(CFG_WORDS*8-1){1'b0}}, bad};
  // One strobe every other cycle
  task automatic burst(input int lane, input int kind, input int n);
    repeat (n) begin
      @(posedge clk_i);
      lane_err_o[lane] <= slethm_err_t'(3'b100 >> kind);
      @(posedge clk_i);
      lane_err_o <= '0;
    end
  endtask
  task automatic set_bad(input logic b);
    @(posedge clk_i);
    bad <= b;
  endtask
endmodule
`default_nettype wire
